// >>> hdl/scc_ctrl.sv
/*
 * sync, clamp and clock source control: apb register file, pin
 * synchronisers, sync-on-green copy, clamp window (pin or counted),
 * coast hold and pixel clock source choice.
 * assumes one 40 mhz clock, synchronous active-high reset, pins
 * asynchronous to clk_i, and an apb3 master per scc_pkg.
 */
`timescale 1ns/1ps

// What this block does
// - copy sync-on-green comparator to output, uninverted
// - clamp pin honoured only when enable set
// - otherwise clamp counted from hsync trailing edge
// - clamp pin active level set by polarity
// - clamp to ground for rgb, midscale yuv
// - coast freezes clock generator frequency and phase
// - coast polarity selectable, resets to one
// - external clock select picks external pixel clock
// - phase adjustment still applies with external clock
// - hsync edge select; leading clocks, trailing clamps
module scc_ctrl (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire scc_pkg::scc_apb_req_t apb_i,
	output logic [31:0]               prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	input  wire logic                 hsync_i,
	input  wire logic                 green_sync_input_i,
	input  wire logic                 clamp_pin_i,
	input  wire logic                 coast_i,
	input  wire logic                 ext_pixel_clock_in_i,
	input  wire logic                 pll_clock_i,
	output logic                      green_sync_output_o,
	output logic                      clamp_active_o,
	output logic                      clamp_midscale_o,
	output logic                      hsync_lead_o,
	output logic                      coast_hold_o,
	output logic                      pixel_clock_o,
	output logic                      ext_clock_sel_o,
	output logic [4:0]                phase_adj_o
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [scc_pkg::PIN_COUNT-1:0] meta;    // first sync stage
		logic [scc_pkg::PIN_COUNT-1:0] pins;    // second sync stage
		logic [scc_pkg::PIN_COUNT-1:0] last;    // pins one cycle ago
		logic [7:0]                    sync_cfg;
		logic [7:0]                    clamp_cfg;
		logic [7:0]                    clk_cfg;
		logic [15:0]                   clamp_tim;
		logic [7:0]                    front_cfg;
		scc_pkg::scc_clamp_st_t        cl_st;   // internal clamp state
		logic [7:0]                    cl_cnt;  // cycles left in phase
		logic                          pready;
		logic                          pslverr;
		logic [31:0]                   prdata;
		logic                          sog;
		logic                          clamp;
		logic                          midscale;
		logic                          lead;
		logic                          coast;
		logic                          pixclk;
	} scc_state_t;

	scc_state_t state_reg;  // registered state
	scc_state_t state_next; // next state

	// decoded pin events, all from the second sync stage or later
	logic hs_lvl;     // hsync in active sense
	logic hs_lvl_old; // previous hsync in active sense
	logic hs_lead;    // leading edge of hsync
	logic hs_trail;   // trailing edge of hsync
	logic coast_act;  // coast pin in active sense
	logic pin_clamp;  // clamp pin in active sense
	logic acc;        // apb access phase awaiting answer
	logic [5:0] idx;  // register index from the byte address
	logic [31:0] rd;  // read mux
	logic hit;        // address maps to a register

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;

		// two-flop synchronisers; meta feeds pins and nothing else
		state_next.meta = {pll_clock_i, ext_pixel_clock_in_i, coast_i,
			clamp_pin_i, green_sync_input_i, hsync_i};
		state_next.pins = state_reg.meta;
		state_next.last = state_reg.pins;

		// hsync sense: inverting a falling-edge sync makes the leading
		// edge a rise in both settings
		hs_lvl = state_reg.pins[scc_pkg::PIN_HSYNC] ~^
			state_reg.sync_cfg[scc_pkg::HSYNC_EDGE_BIT];
		hs_lvl_old = state_reg.last[scc_pkg::PIN_HSYNC] ~^
			state_reg.sync_cfg[scc_pkg::HSYNC_EDGE_BIT];
		hs_lead  = hs_lvl & ~hs_lvl_old;
		hs_trail = ~hs_lvl & hs_lvl_old;

		coast_act = state_reg.pins[scc_pkg::PIN_COAST] ~^
			state_reg.clamp_cfg[scc_pkg::COAST_POL_BIT];
		pin_clamp = state_reg.pins[scc_pkg::PIN_CLAMP] ~^
			state_reg.clamp_cfg[scc_pkg::CLAMP_POL_BIT];

		// sync-on-green passes straight through, no inversion
		state_next.sog = state_reg.pins[scc_pkg::PIN_SOG];

		// coast blocks the tracking pulse and holds the generator;
		// the generator itself keeps its frequency while this is high
		state_next.coast = coast_act;
		state_next.lead  = hs_lead & ~coast_act;

		// pixel clock source; only a sampled copy, so it is a rate
		// indicator for slow clocks, the real mux sits in the clock tree
		state_next.pixclk = state_reg.clk_cfg[scc_pkg::EXT_CLK_BIT] ?
			state_reg.pins[scc_pkg::PIN_EXTCLK] :
			state_reg.pins[scc_pkg::PIN_PLLCLK];

		// internal clamp sequencer: delay then duration, restarted by
		// every trailing edge so a lost sync cannot leave it stuck
		unique case (state_reg.cl_st)
			scc_pkg::CL_IDLE: begin
				state_next.cl_cnt = 8'h00;
			end
			scc_pkg::CL_DELAY: begin
				state_next.cl_cnt = state_reg.cl_cnt - 8'h01;
				if (state_reg.cl_cnt == 8'h01) begin
					state_next.cl_st  = scc_pkg::CL_HOLD;
					state_next.cl_cnt = state_reg.clamp_tim[
						scc_pkg::DUR_LSB +: 8];
					if (state_reg.clamp_tim[scc_pkg::DUR_LSB +: 8] ==
						8'h00) begin
						state_next.cl_st = scc_pkg::CL_IDLE;
					end
				end
			end
			scc_pkg::CL_HOLD: begin
				state_next.cl_cnt = state_reg.cl_cnt - 8'h01;
				if (state_reg.cl_cnt == 8'h01) begin
					state_next.cl_st = scc_pkg::CL_IDLE;
				end
			end
			default: begin
				state_next.cl_st  = scc_pkg::CL_IDLE;
				state_next.cl_cnt = 8'h00;
			end
		endcase
		if (hs_trail) begin
			if (state_reg.clamp_tim[scc_pkg::DELAY_LSB +: 8] != 8'h00)
			begin
				state_next.cl_st  = scc_pkg::CL_DELAY;
				state_next.cl_cnt = state_reg.clamp_tim[
					scc_pkg::DELAY_LSB +: 8];
			end else if (state_reg.clamp_tim[scc_pkg::DUR_LSB +: 8] !=
				8'h00) begin
				state_next.cl_st  = scc_pkg::CL_HOLD;
				state_next.cl_cnt = state_reg.clamp_tim[
					scc_pkg::DUR_LSB +: 8];
			end else begin
				state_next.cl_st = scc_pkg::CL_IDLE;
			end
		end

		// clamp source: pin only when enabled, else the counted window
		if (state_reg.clamp_cfg[scc_pkg::EXT_CLAMP_BIT]) begin
			state_next.clamp = pin_clamp;
		end else begin
			state_next.clamp = (state_reg.cl_st == scc_pkg::CL_HOLD);
		end
		state_next.midscale = state_reg.front_cfg[scc_pkg::YUV_BIT];

		// apb slave: answer one cycle into the access phase
		acc = apb_i.psel & apb_i.penable & ~state_reg.pready;
		idx = apb_i.paddr[7:2];
		hit = 1'b1;
		rd  = 32'h0000_0000;
		unique case (idx)
			scc_pkg::IDX_SYNC_CFG:  rd = {24'h000000, state_reg.sync_cfg};
			scc_pkg::IDX_CLAMP_CFG: rd = {24'h000000, state_reg.clamp_cfg};
			scc_pkg::IDX_CLK_CFG:   rd = {24'h000000, state_reg.clk_cfg};
			scc_pkg::IDX_CLAMP_TIM: rd = {16'h0000, state_reg.clamp_tim};
			scc_pkg::IDX_FRONT_CFG: rd = {24'h000000, state_reg.front_cfg};
			scc_pkg::IDX_STATUS: begin
				rd = {24'h000000, state_reg.cl_cnt} << 8;
				rd[5:0] = {state_reg.cl_st, state_reg.pixclk,
					state_reg.coast, state_reg.clamp, state_reg.sog};
			end
			default: hit = 1'b0;
		endcase
		state_next.pready  = acc;
		state_next.pslverr = acc & ~hit;
		state_next.prdata  = acc ? rd : 32'h0000_0000;

		// writes take effect on the edge that sees pready high
		if (apb_i.psel & apb_i.penable & state_reg.pready &
			apb_i.pwrite) begin
			unique case (idx)
				scc_pkg::IDX_SYNC_CFG:
					state_next.sync_cfg = apb_i.pwdata[7:0];
				scc_pkg::IDX_CLAMP_CFG:
					state_next.clamp_cfg = apb_i.pwdata[7:0];
				scc_pkg::IDX_CLK_CFG:
					state_next.clk_cfg = apb_i.pwdata[7:0];
				scc_pkg::IDX_CLAMP_TIM:
					state_next.clamp_tim = apb_i.pwdata[15:0];
				scc_pkg::IDX_FRONT_CFG:
					state_next.front_cfg = apb_i.pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg           <= '0;
			state_reg.sync_cfg  <= scc_pkg::RST_SYNC_CFG;
			state_reg.clamp_cfg <= scc_pkg::RST_CLAMP_CFG;
			state_reg.clk_cfg   <= scc_pkg::RST_CLK_CFG;
			state_reg.clamp_tim <= scc_pkg::RST_CLAMP_TIM;
			state_reg.front_cfg <= scc_pkg::RST_FRONT_CFG;
			state_reg.cl_st     <= scc_pkg::CL_IDLE;
			// hsync stages start at the idle level of the reset edge
			// choice; zeros here would fake a trailing edge on release
			// and open a clamp window nobody asked for
			state_reg.meta[scc_pkg::PIN_HSYNC] <=
				~scc_pkg::RST_SYNC_CFG[scc_pkg::HSYNC_EDGE_BIT];
			state_reg.pins[scc_pkg::PIN_HSYNC] <=
				~scc_pkg::RST_SYNC_CFG[scc_pkg::HSYNC_EDGE_BIT];
			state_reg.last[scc_pkg::PIN_HSYNC] <=
				~scc_pkg::RST_SYNC_CFG[scc_pkg::HSYNC_EDGE_BIT];
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign prdata_o            = state_reg.prdata;
	assign pready_o            = state_reg.pready;
	assign pslverr_o           = state_reg.pslverr;
	assign green_sync_output_o = state_reg.sog;
	assign clamp_active_o      = state_reg.clamp;
	assign clamp_midscale_o    = state_reg.midscale;
	assign hsync_lead_o        = state_reg.lead;
	assign coast_hold_o        = state_reg.coast;
	assign pixel_clock_o       = state_reg.pixclk;
	assign ext_clock_sel_o     = state_reg.clk_cfg[scc_pkg::EXT_CLK_BIT];
	// phase is applied whichever clock source is chosen
	assign phase_adj_o = state_reg.front_cfg[scc_pkg::PHASE_MSB:0];

endmodule

// >>> hdl/scc_pkg.sv
/*
 * package for the sync, clamp and clock source control block:
 * register indices, field positions, reset values, state codes and
 * the carrier struct for the apb request.
 * assumes an apb3 master with 32-bit data and byte address = 4 * index.
 */
package scc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_SYNC_CFG  = 6'h0e; // hsync edge select
	localparam logic [5:0] IDX_CLAMP_CFG = 6'h0f; // clamp / coast control
	localparam logic [5:0] IDX_CLK_CFG   = 6'h15; // pixel clock source
	localparam logic [5:0] IDX_CLAMP_TIM = 6'h20; // internal clamp timing
	localparam logic [5:0] IDX_FRONT_CFG = 6'h21; // phase and colour space
	localparam logic [5:0] IDX_STATUS    = 6'h22; // live state, read only

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int HSYNC_EDGE_BIT = 6; // 0: falling leads, 1: rising
	localparam int EXT_CLAMP_BIT  = 7; // 1: honour the clamp pin
	localparam int CLAMP_POL_BIT  = 6; // 1: clamp pin active high
	localparam int COAST_POL_BIT  = 3; // 1: coast pin active high
	localparam int EXT_CLK_BIT    = 0; // 1: external pixel clock
	localparam int YUV_BIT        = 7; // 1: yuv inputs, clamp midscale
	localparam int PHASE_MSB      = 4; // sampling phase field [4:0]
	localparam int DELAY_LSB      = 0; // clamp start delay [7:0]
	localparam int DUR_LSB        = 8; // clamp duration [15:8]

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_SYNC_CFG  = 8'h00;
	localparam logic [7:0]  RST_CLAMP_CFG = 8'h08; // coast polarity = 1
	localparam logic [7:0]  RST_CLK_CFG   = 8'h00;
	localparam logic [15:0] RST_CLAMP_TIM = 16'h1008;
	localparam logic [7:0]  RST_FRONT_CFG = 8'h00;

	// ----------------------------------------------------------------
	// synchroniser lanes
	// ----------------------------------------------------------------
	localparam int PIN_HSYNC  = 0;
	localparam int PIN_SOG    = 1;
	localparam int PIN_CLAMP  = 2;
	localparam int PIN_COAST  = 3;
	localparam int PIN_EXTCLK = 4;
	localparam int PIN_PLLCLK = 5;
	localparam int PIN_COUNT  = 6;

	// internal clamp sequencer
	typedef enum logic [1:0] {
		CL_IDLE  = 2'b00,
		CL_DELAY = 2'b01,
		CL_HOLD  = 2'b10
	} scc_clamp_st_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} scc_apb_req_t;

endpackage

// >>> test/scc_monitor.sv
/* checker for scc_ctrl: apb answer timing, sync copy, coast, writes.
   assumes it is bound to scc_ctrl and sees only its ports. */
`timescale 1ns/1ps
module scc_monitor (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire scc_pkg::scc_apb_req_t apb_i,
	input  wire logic [31:0]           prdata_o,
	input  wire logic                  pready_o,
	input  wire logic                  pslverr_o,
	input  wire logic                  green_sync_input_i,
	input  wire logic                  green_sync_output_o,
	input  wire logic                  hsync_lead_o,
	input  wire logic                  coast_hold_o,
	input  wire logic                  ext_clock_sel_o,
	input  wire logic [4:0]            phase_adj_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic [1:0] up_reg;  // edges since reset, stops at 3
	logic       wr_done; // a write completes at this edge
	assign wr_done = apb_i.psel && apb_i.penable && apb_i.pwrite && pready_o;
	// synchroniser output is meaningless right after reset
	always_ff @(posedge clk_i) begin
		if (rst_i)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_setup;
		apb_i.psel && !apb_i.penable;
	endsequence
	sequence s_access;
		apb_i.psel && apb_i.penable;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_ready_wait: assert property (s_setup ##1 s_access |=> pready_o)
		else $error("access not answered after one wait cycle");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held longer than one cycle");
	a_err_pair: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside the answer cycle");
	a_sog_copy: assert property (up_reg == 2'h3 |->
		green_sync_output_o == $past(green_sync_input_i, 3))
		else $error("green sync output is not the delayed input");
	a_coast_mute: assert property (coast_hold_o && $past(coast_hold_o) |->
		!hsync_lead_o)
		else $error("leading edge passed while coasting");
	a_sel_by_write: assert property ($changed(ext_clock_sel_o) |->
		$past(wr_done))
		else $error("clock select changed without a write");
	a_phase_by_write: assert property ($changed(phase_adj_o) |->
		$past(wr_done))
		else $error("phase changed without a write");
endmodule

// >>> test/scc_source_model.sv
/* graphics source model: 64-clock lines, 8-clock low sync pulse,
   back porch clamp pulse, eight clocks. assumes the bench clock. */
`timescale 1ns/1ps
module scc_source_model (
	input  wire logic clk_i,
	input  wire logic run_i,
	output logic      hsync_o,
	output logic      sog_o,
	output logic      clamp_o,
	output logic      extclk_o,
	output logic      pllclk_o
);
	logic [5:0] pos_reg; // position within the line, cleared while idle
	// line counter, parked at zero while idle
	always_ff @(posedge clk_i) begin
		pos_reg <= run_i ? pos_reg + 6'h1 : 6'h0;
	end
	assign hsync_o  = !(run_i && pos_reg < 6'h08); // low going sync
	assign sog_o    = hsync_o; // composite sync carried on green
	assign clamp_o  = run_i && pos_reg >= 6'h0c && pos_reg < 6'h14;
	assign extclk_o = run_i && pos_reg[2];
	assign pllclk_o = pos_reg[1]; // generated clock, period 4
endmodule

// >>> test/scc_ctrl_tb.sv
/* bench for scc_ctrl: apb tasks, defaults, clamp, coast, clocks.
   assumes scc_source_model drives the pins but coast, which the bench drives, scc_monitor is bound. */
`timescale 1ns/1ps
module scc_ctrl_tb;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	scc_pkg::scc_apb_req_t apb_i = '0;
	logic                  hs, sog, clp, ext, pll, er;
	logic                  coast_i = 1'b0, run = 1'b0;
	logic                  rdy, err, sog_o, clamp_o, mid_o, lead_o;
	logic                  hold_o, pix_o, sel_o;
	logic [4:0]            phase_o;
	logic [31:0]           prdata_o, rd;
	int                    n_fail = 0, n_tests = 0, a, b;
	// register walk: reset values, an unmapped slot, then live status
	logic [7:0]  adr [7] = '{8'h38, 8'h3c, 8'h54, 8'h80, 8'h84, 8'h40,
		8'h88};
	// status at rest: only the idle-high sync seen on green
	logic [31:0] exv [7] = '{32'h0, 32'h8, 32'h0, 32'h1008, 32'h0, 32'h0,
		32'h1};
	always #12.5 clk_i = ~clk_i;
	scc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_i),
		.prdata_o(prdata_o), .pready_o(rdy), .pslverr_o(err),
		.hsync_i(hs), .green_sync_input_i(sog), .clamp_pin_i(clp),
		.coast_i(coast_i), .ext_pixel_clock_in_i(ext), .pll_clock_i(pll),
		.green_sync_output_o(sog_o), .clamp_active_o(clamp_o),
		.clamp_midscale_o(mid_o), .hsync_lead_o(lead_o),
		.coast_hold_o(hold_o), .pixel_clock_o(pix_o),
		.ext_clock_sel_o(sel_o), .phase_adj_o(phase_o));
	scc_source_model src (.clk_i(clk_i), .run_i(run), .hsync_o(hs),
		.sog_o(sog), .clamp_o(clp), .extclk_o(ext), .pllclk_o(pll));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; request held until ready is sampled high
	task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd);
		@(posedge clk_i);
		apb_i <= '{1'b1, 1'b0, w, ad, wd};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		repeat (20) begin
			@(posedge clk_i);
			if (rdy === 1'b1) break;
		end
		if (rdy !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		rd = prdata_o;
		er = err;
		apb_i <= '0;
	endtask
	// gap from leading pulse to clamp start, then clamp width
	task automatic meas(output int gap, output int wid);
		gap = 0;
		wid = 0;
		repeat (200) begin
			@(negedge clk_i);
			if (lead_o === 1'b1) break;
		end
		if (lead_o !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		while (clamp_o === 1'b1 && gap < 200) @(negedge clk_i);
		while (clamp_o !== 1'b1 && gap < 200) begin
			@(negedge clk_i);
			gap++;
		end
		while (clamp_o === 1'b1 && wid < 200) begin
			@(negedge clk_i);
			wid++;
		end
	endtask
	// rising transitions of a signal over len cycles
	// lead selects the lead pulse, otherwise the pixel clock copy
	task automatic rises(input logic lead, input int len, output int n);
		logic p, s;
		n = 0;
		p = lead ? lead_o : pix_o;
		repeat (len) begin
			@(negedge clk_i);
			s = lead ? lead_o : pix_o;
			if (s === 1'b1 && p === 1'b0) n++;
			p = s;
		end
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (a = 0; a < 7; a++) begin
			apb(1'b0, adr[a], 32'h0);
			chk("reg", exv[a], rd);
			chk("err", 32'(a == 5), {31'h0, er});
		end
		chk("mid", 32'h0, {31'h0, mid_o});
		apb(1'b1, 8'h80, 32'h0203);
		apb(1'b1, 8'h84, 32'h85);
		run <= 1'b1;
		repeat (70) @(posedge clk_i);
		chk("mid", 32'h1, {31'h0, mid_o});
		chk("phase", 32'h5, {27'h0, phase_o});
		meas(a, b);
		chk("gap", 32'd12, a);
		chk("width", 32'd2, b);
		apb(1'b1, 8'h38, 32'h40);
		meas(a, b);
		meas(a, b);
		chk("gap", 32'd60, a);
		apb(1'b1, 8'h38, 32'h0);
		apb(1'b1, 8'h3c, 32'hc8);
		meas(a, b);
		meas(a, b);
		chk("width", 32'd8, b);
		apb(1'b1, 8'h3c, 32'h88);
		meas(a, b);
		meas(a, b);
		chk("width", 32'd56, b);
		apb(1'b1, 8'h3c, 32'h08);
		rises(1'b0, 64, a);
		chk("pll", 32'd16, a);
		apb(1'b1, 8'h54, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("sel", 32'h1, {31'h0, sel_o});
		chk("phase", 32'h5, {27'h0, phase_o});
		rises(1'b0, 64, a);
		chk("ext", 32'd8, a);
		coast_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("coast", 32'h1, {31'h0, hold_o});
		rises(1'b1, 128, a);
		chk("lead", 32'd0, a);
		coast_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rises(1'b1, 128, a);
		chk("lead", 32'd2, a);
		apb(1'b1, 8'h3c, 32'h0);
		repeat (8) @(posedge clk_i);
		chk("coast", 32'h1, {31'h0, hold_o});
		give_verdict();
	end
endmodule

bind scc_ctrl scc_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
	.apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .green_sync_input_i(green_sync_input_i),
	.green_sync_output_o(green_sync_output_o),
	.hsync_lead_o(hsync_lead_o), .coast_hold_o(coast_hold_o),
	.ext_clock_sel_o(ext_clock_sel_o), .phase_adj_o(phase_adj_o));
